// file: rtl/afsl_cfg.svh
// Purpose: Register map, reset values, bit positions and timing counts for the axis fault status logic.
// Assumes: 200 MHz pclk, APB with 32-bit data, one word per register.
// Notes: Timing counts are derived from times in microseconds.
// Contract
// [RULE_01] Resolver rate: 0 off, 1..8 doubling periods
// [RULE_02] Resolver rate change waits for controller reset
// [RULE_03] Scan rate: 0 off, 1.6-12.8 ms, default 2
// [RULE_04] Loop checks off blocks bits 12-15
// [RULE_05] Slot merge gives task-2 slots to task 1
// [RULE_06] Invert mask bit inverts raw status bit
// [RULE_07] Inverted limit/user input: low reads one
// [RULE_08] Invert mask resets to 0x329
// [RULE_09] Software changes only limit and user-input bits; the polarity mask write here takes all 24 bits
// [RULE_10] Masks share error word bit positions
// [RULE_11] Bits 0-5: feedback, drive, user inputs
// [RULE_12] Bits 6-11: limits, reserved, resolver error
// [RULE_13] Bits 12-15: loop traps
// [RULE_14] Bits 16-21 software/runtime/calibration; 22-23 reserved
// [RULE_15] Default actions: feedhold, task stops, amp off
// [RULE_16] Scan tick loads raw xor mask
`ifndef AFSL_CFG_SVH
`define AFSL_CFG_SVH
`define AFSL_OFF_ERROR 12'h000
`define AFSL_OFF_POLARITY 12'h004
`define AFSL_OFF_RESOLVER 12'h008
`define AFSL_OFF_SCAN 12'h00C
`define AFSL_OFF_LOOPCHK 12'h010
`define AFSL_OFF_MERGE 12'h014
`define AFSL_OFF_ACTIVE 12'h018
`define AFSL_OFF_CTRLRST 12'h01C
`define AFSL_RST_POLARITY 24'h00_0329
`define AFSL_RST_RESOLVER 4'h0
`define AFSL_RST_SCAN 3'h2
`define AFSL_RST_LOOPCHK 1'b1
`define AFSL_RST_MERGE 1'b0
`define AFSL_RSVD_MASK 24'hC0_0400
`define AFSL_TRAP_MASK 24'h00_F000
`define AFSL_BIT_FEEDHOLD 3
`define AFSL_BIT_STOP_T1 16
`define AFSL_BIT_STOP_T2 17
`define AFSL_BIT_AMP_OFF 18
`define AFSL_BASE_US 100
`define AFSL_CLK_MHZ 200
`define AFSL_BASE_CYC (`AFSL_BASE_US * `AFSL_CLK_MHZ)
`define AFSL_SCAN_BASE_US 1600
`define AFSL_SCAN_BASE_CYC (`AFSL_SCAN_BASE_US * `AFSL_CLK_MHZ)
`endif

// file: rtl/afsl_pkg.sv
// Purpose: Types for the axis fault status logic.
// Assumes: Constants live in afsl_cfg.svh.
// Notes: None.
package afsl_pkg;
  typedef logic [23:0] afsl_word_t;
  typedef enum logic [2:0] {
    AFSL_IDLE = 3'b001,
    AFSL_SETUP = 3'b010,
    AFSL_ACCESS = 3'b100
  } afsl_apb_t;
endpackage

// file: rtl/afsl_fault_status.sv
// Purpose: Error status word, polarity mask, rate selects and loop settings of one axis.
// Assumes: Raw inputs are asynchronous pins or software trap levels; APB slave, zero wait.
// Notes: The pending resolver rate applies on a controller reset write; scan rate writes apply at once.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "afsl_cfg.svh"
module afsl_fault_status
  import afsl_pkg::*;
#(
  parameter int BASE_CYC = `AFSL_BASE_CYC,
  parameter int SCAN_BASE_CYC = `AFSL_SCAN_BASE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Raw fault sources
  input wire logic [23:0] raw_status,
  // Settings and actions
  output logic resolver_tick,
  output logic [3:0] resolver_rate_active,
  output logic loop_check_enable,
  output logic task_slot_merge,
  output logic fast_feedhold,
  output logic stop_task1,
  output logic stop_task2,
  output logic amp_disable
);
  afsl_word_t sync1_r, sync2_r, err_r, err_nxt, pol_r, pol_nxt;
  logic [3:0] res_sel_r, res_sel_nxt, res_act_r, res_act_nxt;
  logic [2:0] scan_r, scan_nxt;
  logic lchk_r, lchk_nxt, merge_r, merge_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic [31:0] scan_cnt_r, scan_cnt_nxt, res_cnt_r, res_cnt_nxt;
  logic scan_tick, res_tick_nxt, res_tick_r;
  logic acc, wr, hit;

  // Scan period in cycles
  function automatic logic [31:0] scan_period(input logic [2:0] code);
    scan_period = 32'(SCAN_BASE_CYC) << (code - 3'd1);
  endfunction

  // Resolver period in cycles
  function automatic logic [31:0] res_period(input logic [3:0] code);
    res_period = 32'(BASE_CYC) << (code - 4'd1);
  endfunction

  // Two-stage synchroniser for raw sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (clk_en) begin
      sync1_r <= raw_status;
      sync2_r <= sync1_r;
    end
  end

  assign acc = psel && penable;
  assign wr = acc && pwrite;

  always_comb begin
    pol_nxt = pol_r;
    res_sel_nxt = res_sel_r;
    res_act_nxt = res_act_r;
    scan_nxt = scan_r;
    lchk_nxt = lchk_r;
    merge_nxt = merge_r;
    hit = 1'b1;
    prdata_nxt = '0;
    unique case (paddr)
      `AFSL_OFF_ERROR: prdata_nxt = {8'h00, err_r};
      `AFSL_OFF_POLARITY: prdata_nxt = {8'h00, pol_r};
      `AFSL_OFF_RESOLVER: prdata_nxt = {28'h000_0000, res_sel_r};
      `AFSL_OFF_SCAN: prdata_nxt = {29'h0000_0000, scan_r};
      `AFSL_OFF_LOOPCHK: prdata_nxt = {31'h0000_0000, lchk_r};
      `AFSL_OFF_MERGE: prdata_nxt = {31'h0000_0000, merge_r};
      `AFSL_OFF_ACTIVE: prdata_nxt = {28'h000_0000, res_act_r};
      `AFSL_OFF_CTRLRST: prdata_nxt = '0;
      default: hit = 1'b0;
    endcase
    if (wr) begin
      unique case (paddr)
        // [RULE_08] [RULE_10] Polarity mask write
        `AFSL_OFF_POLARITY: pol_nxt = pwdata[23:0];
        // [RULE_01] Codes above 8 ignored
        `AFSL_OFF_RESOLVER: if (pwdata[3:0] <= 4'd8) res_sel_nxt = pwdata[3:0];
        // [RULE_03] Codes above 4 ignored
        `AFSL_OFF_SCAN: if (pwdata[2:0] <= 3'd4) scan_nxt = pwdata[2:0];
        `AFSL_OFF_LOOPCHK: lchk_nxt = pwdata[0];
        `AFSL_OFF_MERGE: merge_nxt = pwdata[0];
        // [RULE_02] Controller reset applies resolver rate
        `AFSL_OFF_CTRLRST: if (pwdata[0]) res_act_nxt = res_sel_r;
        default: ;
      endcase
    end
    pready_nxt = 1'b1;
    pslverr_nxt = psel && !penable && !hit;
    if (!(psel && !penable) || pwrite) prdata_nxt = '0;
  end

  // Scan and resolver timers
  always_comb begin
    scan_tick = 1'b0;
    scan_cnt_nxt = scan_cnt_r + 32'd1;
    if (scan_r == 3'd0) begin
      scan_cnt_nxt = '0;
    end else if (scan_cnt_r >= scan_period(scan_r) - 32'd1) begin
      scan_cnt_nxt = '0;
      scan_tick = 1'b1;
    end
    res_tick_nxt = 1'b0;
    res_cnt_nxt = res_cnt_r + 32'd1;
    if (res_act_r == 4'd0) begin
      res_cnt_nxt = '0;
    end else if (res_cnt_r >= res_period(res_act_r) - 32'd1) begin
      res_cnt_nxt = '0;
      res_tick_nxt = 1'b1;
    end
    err_nxt = err_r;
    // [RULE_16] [RULE_06] [RULE_07] Load on scan tick only
    if (scan_tick) begin
      err_nxt = sync2_r ^ pol_r;
      // [RULE_04] Loop traps blocked when checks off
      if (!lchk_r) err_nxt = err_nxt & ~`AFSL_TRAP_MASK;
      // [RULE_12] [RULE_14] Reserved bits read zero
      err_nxt = err_nxt & ~`AFSL_RSVD_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r <= '0;
      pol_r <= `AFSL_RST_POLARITY;
      res_sel_r <= `AFSL_RST_RESOLVER;
      res_act_r <= `AFSL_RST_RESOLVER;
      scan_r <= `AFSL_RST_SCAN;
      lchk_r <= `AFSL_RST_LOOPCHK;
      merge_r <= `AFSL_RST_MERGE;
      scan_cnt_r <= '0;
      res_cnt_r <= '0;
      res_tick_r <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      err_r <= err_nxt;
      pol_r <= pol_nxt;
      res_sel_r <= res_sel_nxt;
      res_act_r <= res_act_nxt;
      scan_r <= scan_nxt;
      lchk_r <= lchk_nxt;
      merge_r <= merge_nxt;
      scan_cnt_r <= scan_cnt_nxt;
      res_cnt_r <= res_cnt_nxt;
      res_tick_r <= res_tick_nxt;
      if (psel && !penable) begin
        prdata <= prdata_nxt;
        pslverr <= pslverr_nxt;
      end
      pready <= pready_nxt;
    end
  end

  // [RULE_11] [RULE_13] [RULE_15] Default actions from status word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_feedhold <= 1'b0;
      stop_task1 <= 1'b0;
      stop_task2 <= 1'b0;
      amp_disable <= 1'b0;
      resolver_tick <= 1'b0;
      resolver_rate_active <= `AFSL_RST_RESOLVER;
      loop_check_enable <= `AFSL_RST_LOOPCHK;
      task_slot_merge <= `AFSL_RST_MERGE;
    end else if (clk_en) begin
      fast_feedhold <= err_r[`AFSL_BIT_FEEDHOLD];
      stop_task1 <= err_r[`AFSL_BIT_STOP_T1];
      // [RULE_05] Merge disables task 2
      stop_task2 <= err_r[`AFSL_BIT_STOP_T2] || merge_r;
      amp_disable <= err_r[`AFSL_BIT_AMP_OFF];
      resolver_tick <= res_tick_r;
      resolver_rate_active <= res_act_r;
      loop_check_enable <= lchk_r;
      task_slot_merge <= merge_r;
    end
  end

  // Bus phases used by the checks below
  sequence s_setup_rd;
    clk_en && psel && !penable && !pwrite;
  endsequence
  sequence s_setup_wr;
    clk_en && psel && !penable && pwrite;
  endsequence
  sequence s_acc_wr;
    clk_en && psel && penable && pwrite;
  endsequence
  sequence s_ctrl_rst;
    clk_en && psel && penable && pwrite && paddr == `AFSL_OFF_CTRLRST && pwdata[0];
  endsequence

  // [RULE_04] Trap bits stay clear with checks off
  a_trap_blocked: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    clk_en && scan_tick && !lchk_r |=> (err_r[15:12] == 4'h0))
    else $error("trap bit set while loop checks off");
  // [RULE_16] Scan loads raw xor mask
  a_scan_load: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    clk_en && scan_tick && lchk_r |=> (err_r == ((($past(sync2_r) ^ $past(pol_r))) & ~`AFSL_RSVD_MASK)))
    else $error("status word not raw xor mask");
  // [RULE_16] No update with scan off
  a_scan_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    scan_r == 3'd0 ##1 scan_r == 3'd0 |-> $stable(err_r))
    else $error("status changed with scan off");
  // [RULE_02] Active resolver rate moves only on controller reset
  a_res_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    !(clk_en && wr && paddr == `AFSL_OFF_CTRLRST && pwdata[0]) |=> $stable(res_act_r))
    else $error("resolver rate changed without reset");
  // [RULE_12] Reserved bits zero
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
    (err_r & `AFSL_RSVD_MASK) == 24'h00_0000)
    else $error("reserved status bit set");
  // [RULE_05] Merge stops task 2
  a_merge_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    clk_en && merge_r |=> stop_task2)
    else $error("task 2 not stopped under merge");
  // [RULE_03] Scan code in range
  a_scan_range: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    scan_r <= 3'd4)
    else $error("scan code out of range");
  // [RULE_01] Resolver code in range
  a_res_range: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    res_sel_r <= 4'd8 && res_act_r <= 4'd8)
    else $error("resolver code out of range");
  // [RULE_11] Error word read back
  a_rd_error: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
    s_setup_rd ##0 (paddr == `AFSL_OFF_ERROR) |=> prdata == {8'h00, $past(err_r)})
    else $error("error word read mismatch");
  // [RULE_10] Polarity mask read back
  a_rd_polarity: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    s_setup_rd ##0 (paddr == `AFSL_OFF_POLARITY) |=> prdata == {8'h00, $past(pol_r)})
    else $error("polarity mask read mismatch");
  // [RULE_01] Pending resolver code read back
  a_rd_resolver: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    s_setup_rd ##0 (paddr == `AFSL_OFF_RESOLVER) |=> prdata == {28'h000_0000, $past(res_sel_r)})
    else $error("resolver select read mismatch");
  // [RULE_03] Scan code read back
  a_rd_scan: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    s_setup_rd ##0 (paddr == `AFSL_OFF_SCAN) |=> prdata == {29'h0000_0000, $past(scan_r)})
    else $error("scan rate read mismatch");
  // [RULE_04] Loop check read back
  a_rd_loopchk: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    s_setup_rd ##0 (paddr == `AFSL_OFF_LOOPCHK) |=> prdata == {31'h0000_0000, $past(lchk_r)})
    else $error("loop check read mismatch");
  // [RULE_05] Slot merge read back
  a_rd_merge: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    s_setup_rd ##0 (paddr == `AFSL_OFF_MERGE) |=> prdata == {31'h0000_0000, $past(merge_r)})
    else $error("slot merge read mismatch");
  // [RULE_02] Active resolver code read back
  a_rd_active: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    s_setup_rd ##0 (paddr == `AFSL_OFF_ACTIVE) |=> prdata == {28'h000_0000, $past(res_act_r)})
    else $error("active resolver read mismatch");
  // [RULE_10] Writes return zero data
  a_wr_rdata_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    s_setup_wr |=> prdata == 32'h0000_0000)
    else $error("read data not zero on write");
  // [RULE_10] Offsets above the controller reset offset flag an error
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    clk_en && psel && !penable && paddr > `AFSL_OFF_CTRLRST |=> pslverr)
    else $error("unmapped access without error");
  // [RULE_10] Error word offset answers cleanly
  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    clk_en && psel && !penable && paddr == `AFSL_OFF_ERROR |=> !pslverr)
    else $error("mapped access flagged error");
  // [RULE_10] Zero wait answer after reset
  a_pready_up: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
    clk_en ##1 clk_en |=> pready)
    else $error("ready not high");
  // [RULE_06] Polarity mask write lands
  a_pol_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
    s_acc_wr ##0 (paddr == `AFSL_OFF_POLARITY) |=> pol_r == $past(pwdata[23:0]))
    else $error("polarity mask write lost");
  // [RULE_03] Legal scan code write lands
  a_scan_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    s_acc_wr ##0 (paddr == `AFSL_OFF_SCAN && pwdata[2:0] <= 3'd4) |=> scan_r == $past(pwdata[2:0]))
    else $error("scan code write lost");
  // [RULE_03] Illegal scan code refused
  a_scan_refuse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    s_acc_wr ##0 (paddr == `AFSL_OFF_SCAN && pwdata[2:0] > 3'd4) |=> $stable(scan_r))
    else $error("illegal scan code taken");
  // [RULE_01] Legal resolver code write lands
  a_res_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    s_acc_wr ##0 (paddr == `AFSL_OFF_RESOLVER && pwdata[3:0] <= 4'd8) |=> res_sel_r == $past(pwdata[3:0]))
    else $error("resolver code write lost");
  // [RULE_01] Illegal resolver code refused
  a_res_refuse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    s_acc_wr ##0 (paddr == `AFSL_OFF_RESOLVER && pwdata[3:0] > 4'd8) |=> $stable(res_sel_r))
    else $error("illegal resolver code taken");
  // [RULE_02] Controller reset applies pending code
  a_res_apply: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    s_ctrl_rst |=> res_act_r == $past(res_sel_r))
    else $error("pending resolver code not applied");
  // [RULE_04] Loop check write lands
  a_lchk_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    s_acc_wr ##0 (paddr == `AFSL_OFF_LOOPCHK) |=> lchk_r == $past(pwdata[0]))
    else $error("loop check write lost");
  // [RULE_05] Slot merge write lands
  a_merge_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    s_acc_wr ##0 (paddr == `AFSL_OFF_MERGE) |=> merge_r == $past(pwdata[0]))
    else $error("slot merge write lost");
  // [RULE_16] Disabled clock freezes state
  a_freeze: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    !clk_en |=> $stable(err_r) && $stable(pol_r) && $stable(res_act_r))
    else $error("state moved while frozen");
  // [RULE_16] Status word holds between ticks
  a_hold_between: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_16]
    clk_en && !scan_tick |=> $stable(err_r))
    else $error("status word changed without tick");
  // [RULE_15] Feedhold follows user input 2
  a_feedhold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    clk_en |=> fast_feedhold == $past(err_r[`AFSL_BIT_FEEDHOLD]))
    else $error("feedhold not following status");
  // [RULE_15] Task 1 stop follows trap 1
  a_stop_task1: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    clk_en |=> stop_task1 == $past(err_r[`AFSL_BIT_STOP_T1]))
    else $error("task 1 stop not following status");
  // [RULE_15] Amplifier off follows trap 3
  a_amp_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    clk_en |=> amp_disable == $past(err_r[`AFSL_BIT_AMP_OFF]))
    else $error("amplifier off not following status");
  // [RULE_01] No resolver tick while off
  a_res_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    clk_en && res_act_r == 4'd0 |=> !res_tick_r)
    else $error("resolver tick while off");
  // [RULE_04] Loop check output follows setting
  a_loop_out: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    clk_en |=> loop_check_enable == $past(lchk_r))
    else $error("loop check output stale");
  // [RULE_05] Merge output follows setting
  a_merge_out: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
    clk_en |=> task_slot_merge == $past(merge_r))
    else $error("slot merge output stale");
endmodule

// file: sim/afsl_raw_src.sv
// Purpose: Far-side fault sources (limits, user inputs, drive, feedback) of one axis.
// Assumes: The bench asks for a level pattern; the pins follow one clock later.
// Notes: Levels only, no glitches.
`timescale 1ns/1ps
module afsl_raw_src (
  // Clock
  input wire logic pclk,
  // Requested and driven levels
  input wire logic [23:0] want,
  output logic [23:0] raw_status
);
  always_ff @(posedge pclk) begin
    raw_status <= want;
  end
endmodule

// file: sim/tb_axis_fault_status_logic.sv
// Purpose: Self-checking bench for the axis fault status logic.
// Assumes: Short counts BASE_CYC=4, SCAN_BASE_CYC=16; APB answers when pready is high.
// Notes: Error word model is raw xor mask with reserved bits cleared, and loop bits cleared when loop checks are off.
`timescale 1ns/1ps
module tb_axis_fault_status_logic;
  import afsl_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er, lc;
  logic resolver_tick, loop_check_enable, task_slot_merge;
  logic fast_feedhold, stop_task1, stop_task2, amp_disable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] resolver_rate_active;
  afsl_word_t raw_status, want, mask, w;
  int err_count, compares, seed, g, c;
  logic [31:0] rv [7] = '{32'h0, 32'h0329, 32'h0, 32'h2, 32'h1, 32'h0, 32'h0};
  afsl_fault_status #(.BASE_CYC(4), .SCAN_BASE_CYC(16)) u_dut (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_status(raw_status), .resolver_tick(resolver_tick),
    .resolver_rate_active(resolver_rate_active), .loop_check_enable(loop_check_enable),
    .task_slot_merge(task_slot_merge), .fast_feedhold(fast_feedhold), .stop_task1(stop_task1),
    .stop_task2(stop_task2), .amp_disable(amp_disable));
  afsl_raw_src u_src (.pclk(pclk), .want(want), .raw_status(raw_status));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task gap(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (resolver_tick !== 1'b1 && n < 2000);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (resolver_tick !== 1'b1 && n < 2000);
  endtask
  task tally_and_finish;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #(5 * 60000);
    err_count++;
    tally_and_finish;
  end
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    want = 24'h00_0000;
    seed = 95;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 1; i < 7; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(er), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      c = (i % 4) + 1;
      want <= 24'($random(seed));
      // Only limit and user-input bits change
      mask = 24'h00_0329 ^ (24'($random(seed)) & 24'h00_0328);
      lc = i[0];
      apb(1'b1, 12'h00C, 32'(c));
      apb(1'b1, 12'h004, 32'(mask));
      apb(1'b1, 12'h010, 32'(lc));
      repeat ((32 << (c - 1)) + 8) @(posedge pclk);
      w = (want ^ mask) & ~24'hC0_0400 & (lc ? 24'hFF_FFFF : ~24'h00_F000);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'(w));
      chk(32'({fast_feedhold, stop_task1, amp_disable, loop_check_enable}), 32'({w[3], w[16], w[18], lc}));
    end
    apb(1'b1, 12'h00C, 32'h0);
    want <= ~want;
    repeat (60) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'(w));
    apb(1'b1, 12'h00C, 32'h5);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h014, 32'h1);
    repeat (2) @(negedge pclk);
    chk(32'({task_slot_merge, stop_task2}), 32'h3);
    apb(1'b1, 12'h014, 32'h0);
    repeat (2) @(negedge pclk);
    chk(32'({task_slot_merge, stop_task2}), 32'({1'b0, w[17]}));
    clk_en <= 1'b0;
    repeat (20) @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'(w));
    $display("test status done");
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    for (int k = 1; k < 9; k++) begin
      apb(1'b1, 12'h008, 32'(k));
      apb(1'b1, 12'h01C, 32'h1);
      apb(1'b0, 12'h018, 32'h0);
      chk(rd, 32'(k));
      chk(32'(resolver_rate_active), 32'(k));
      gap(g);
      chk(32'(g), 32'(4 << (k - 1)));
    end
    apb(1'b1, 12'h008, 32'h9);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h8);
    $display("test resolver done");
    tally_and_finish;
  end
endmodule
